// ### hdl/osc_clock_source_select.sv
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "osc_params.svh"
// Contract
// - sysctl enable gates the selected source
// - full-rate output follows the selected source
// - half-rate output is full rate halved
// - wait mode leaves clocks running
// - stop mode halts both clock outputs
// - break state keeps both clocks running
// - two-bit select picks the source
// - generator-on bit starts switch, resets low
// - generator-on ignored in monitor, test modes
// - engaged bit shows external clock drives
// - trim factor sets internal period
// - pin outputs clock for internal, RC
// - pin bit ignored for crystal, external
// - crystal passes through at full rate
// - two edges, switch, engage, stop internal
// - no fallback; internal restarts only on reset
module osc_clock_source_select
    import osc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // source clock levels, synchronous to ref_clk
    input wire logic first_oscillator_pin,
    input wire logic resistor_cap_clock,
    input wire logic crystal_clock,
    // system integration unit
    input wire logic osc_enable_from_sysctl,
    input wire logic stop_mode,
    input wire logic monitor_osc_bypass,
    input wire logic factory_test_mode_a,
    input wire logic factory_test_mode_b,
    output logic full_rate_clock,
    output logic half_rate_clock,
    // second oscillator pin
    output logic second_oscillator_pin_o,
    output logic second_oscillator_pin_oe,
    output logic port_a_bit4_io_sel
);
    // ==========================================================
    // registers and state
    // ==========================================================
    logic ext_clk_gen_on_r;
    logic ext_clk_engaged_r;
    logic [7:0] trim_factor_r;
    osc_src_t source_sel_r;
    logic pin_clock_out_en_r;
    osc_sw_state_t sw_state_r;
    osc_sw_state_t sw_state_nxt;
    logic [1:0] edge_cnt_r;
    logic half_phase_r;
    logic [31:0] prdata_r;

    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic gen_on_eff;
    logic int_run;
    logic int_tick;
    logic pin_tick;
    logic rc_tick;
    logic xtal_tick;
    logic ext_tick;
    logic src_tick;
    logic clk_gate;

    function automatic logic is_mapped(input logic [11:0] a);
        return a == `OSC_ADDR_STATUS || a == `OSC_ADDR_TRIM || a == `OSC_ADDR_CTRL;
    endfunction : is_mapped

    // ==========================================================
    // apb slave: zero wait states, read data captured in setup
    // ==========================================================
    assign addr_ok = is_mapped(paddr);
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_r <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_r <= 32'h00000000;
            unique case (paddr)
                `OSC_ADDR_STATUS: begin
                    prdata_r[`OSC_ST_GEN_ON_BIT] <= ext_clk_gen_on_r;
                    prdata_r[`OSC_ST_ENGAGED_BIT] <= ext_clk_engaged_r;
                end
                `OSC_ADDR_TRIM: begin
                    prdata_r[7:0] <= trim_factor_r;
                end
                `OSC_ADDR_CTRL: begin
                    prdata_r[`OSC_CT_SEL_LSB +: 2] <= source_sel_r;
                    prdata_r[`OSC_CT_PIN_OUT_BIT] <= pin_clock_out_en_r;
                end
                default: begin
                    prdata_r <= 32'h00000000;
                end
            endcase
        end
    end

    // status: only the generator-on bit is writable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_clk_gen_on_r <= 1'b0;
        end else if (wr_en && paddr == `OSC_ADDR_STATUS) begin
            ext_clk_gen_on_r <= pwdata[`OSC_ST_GEN_ON_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trim_factor_r <= `OSC_TRIM_RESET;
        end else if (wr_en && paddr == `OSC_ADDR_TRIM) begin
            trim_factor_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            source_sel_r <= osc_src_t'(`OSC_SEL_RESET);
            pin_clock_out_en_r <= 1'b0;
        end else if (wr_en && paddr == `OSC_ADDR_CTRL) begin
            source_sel_r <= osc_src_t'(pwdata[`OSC_CT_SEL_LSB +: 2]);
            pin_clock_out_en_r <= pwdata[`OSC_CT_PIN_OUT_BIT];
        end
    end

    // ==========================================================
    // sources
    // ==========================================================
    osc_int_gen u_int_gen (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(int_run),
        .trim(trim_factor_r),
        .tick(int_tick)
    );

    osc_edge_tick u_pin_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .level_in(first_oscillator_pin),
        .tick(pin_tick)
    );

    osc_edge_tick u_rc_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .level_in(resistor_cap_clock),
        .tick(rc_tick)
    );

    // crystal edges pass untouched; early cycles may be irregular
    osc_edge_tick u_xtal_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .level_in(crystal_clock),
        .tick(xtal_tick)
    );

    always_comb begin
        unique case (source_sel_r)
            OSC_SRC_EXT_PIN: ext_tick = pin_tick;
            OSC_SRC_RC: ext_tick = rc_tick;
            OSC_SRC_CRYSTAL: ext_tick = xtal_tick;
            OSC_SRC_INTERNAL: ext_tick = 1'b0;
        endcase
    end

    // ==========================================================
    // internal to external switch-over
    // ==========================================================
    // monitor bypass and both test modes mask the request
    assign gen_on_eff = ext_clk_gen_on_r & ~monitor_osc_bypass
        & ~factory_test_mode_a & ~factory_test_mode_b;

    always_comb begin
        sw_state_nxt = sw_state_r;
        unique case (sw_state_r)
            OSC_SW_INTERNAL: begin
                if (gen_on_eff && source_sel_r != OSC_SRC_INTERNAL) begin
                    sw_state_nxt = OSC_SW_COUNT;
                end
            end
            OSC_SW_COUNT: begin
                // switch only on an external edge so no runt pulse appears
                if (ext_tick && edge_cnt_r == `OSC_EDGE_WAIT) begin
                    sw_state_nxt = OSC_SW_ENGAGED;
                end
            end
            OSC_SW_ENGAGED: begin
                sw_state_nxt = OSC_SW_ENGAGED;
            end
            default: begin
                sw_state_nxt = OSC_SW_INTERNAL;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sw_state_r <= OSC_SW_INTERNAL;
        end else begin
            sw_state_r <= sw_state_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            edge_cnt_r <= 2'h0;
        end else if (sw_state_r != OSC_SW_COUNT) begin
            edge_cnt_r <= 2'h0;
        end else if (ext_tick && edge_cnt_r != `OSC_EDGE_WAIT) begin
            edge_cnt_r <= edge_cnt_r + 2'h1;
        end
    end

    // engaged flag set with the state; the internal oscillator stops in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_clk_engaged_r <= 1'b0;
        end else if (sw_state_nxt == OSC_SW_ENGAGED) begin
            ext_clk_engaged_r <= 1'b1;
        end
    end

    // internal oscillator only comes back through reset
    assign int_run = ~ext_clk_engaged_r & osc_enable_from_sysctl & ~stop_mode;

    // ==========================================================
    // clock outputs
    // ==========================================================
    // wait and break have no hold on the gate: only enable and stop act
    assign clk_gate = osc_enable_from_sysctl & ~stop_mode;
    assign src_tick = ext_clk_engaged_r ? ext_tick : int_tick;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            full_rate_clock <= 1'b0;
            half_rate_clock <= 1'b0;
            half_phase_r <= 1'b0;
        end else begin
            full_rate_clock <= src_tick & clk_gate;
            half_rate_clock <= src_tick & clk_gate & half_phase_r;
            if (src_tick && clk_gate) begin
                half_phase_r <= ~half_phase_r;
            end
        end
    end

    // ==========================================================
    // second oscillator pin
    // ==========================================================
    logic pin_clk_mode;
    assign pin_clk_mode = pin_clock_out_en_r
        && (source_sel_r == OSC_SRC_INTERNAL || source_sel_r == OSC_SRC_RC);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            second_oscillator_pin_o <= 1'b0;
            second_oscillator_pin_oe <= 1'b0;
            port_a_bit4_io_sel <= 1'b1;
        end else begin
            second_oscillator_pin_o <= pin_clk_mode & src_tick & clk_gate;
            second_oscillator_pin_oe <= pin_clk_mode;
            // crystal keeps the pin for its amplifier; external pin mode frees it
            port_a_bit4_io_sel <= ~pin_clk_mode && source_sel_r != OSC_SRC_CRYSTAL;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_request;
        gen_on_eff && source_sel_r != OSC_SRC_INTERNAL && sw_state_r == OSC_SW_INTERNAL;
    endsequence

    // last counted external edge: the switch lands on this boundary
    sequence s_last_edge;
        sw_state_r == OSC_SW_COUNT && ext_tick && edge_cnt_r == `OSC_EDGE_WAIT;
    endsequence

    sequence s_engaged;
        ext_clk_engaged_r && sw_state_r == OSC_SW_ENGAGED;
    endsequence

    a_stop_halts: assert property (stop_mode |=> !full_rate_clock && !half_rate_clock)
        else $error("clock output while stopped");
    a_enable_gates: assert property (!osc_enable_from_sysctl |=> !full_rate_clock)
        else $error("clock output while disabled");
    a_half_implies_full: assert property (half_rate_clock |-> full_rate_clock)
        else $error("half rate without full rate");
    a_half_alternates: assert property (half_rate_clock |-> ##1 !half_rate_clock)
        else $error("half rate pulses too close");
    a_masked_request: assert property ((monitor_osc_bypass || factory_test_mode_a)
        && sw_state_r == OSC_SW_INTERNAL |=> sw_state_r == OSC_SW_INTERNAL)
        else $error("switch started in masked mode");
    a_engage_order: assert property (s_request |=> sw_state_r == OSC_SW_COUNT
        && !ext_clk_engaged_r)
        else $error("engaged before edge count");
    a_engage_on_edge: assert property (s_last_edge |=> s_engaged)
        else $error("switch missed the counted edge");
    a_two_edges: assert property ($rose(ext_clk_engaged_r) |-> $past(edge_cnt_r) == 2'h2
        && $past(ext_tick))
        else $error("engaged without two edges");
    a_no_fallback: assert property (ext_clk_engaged_r |=> ext_clk_engaged_r && !int_run)
        else $error("fell back to internal clock");
    a_int_stops: assert property (ext_clk_engaged_r |-> !int_tick)
        else $error("internal oscillator still running");
    a_pin_ignored: assert property (source_sel_r == OSC_SRC_CRYSTAL
        |=> !second_oscillator_pin_oe)
        else $error("pin driven in crystal mode");
    a_pin_clock: assert property (pin_clk_mode |=> second_oscillator_pin_oe)
        else $error("pin clock not enabled");
endmodule : osc_clock_source_select

// ### hdl/osc_params.svh
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH

// register byte offsets
`define OSC_ADDR_STATUS 12'h000
`define OSC_ADDR_TRIM 12'h004
`define OSC_ADDR_CTRL 12'h008

// status fields
`define OSC_ST_ENGAGED_BIT 0
`define OSC_ST_GEN_ON_BIT 1

// control fields
`define OSC_CT_SEL_LSB 0
`define OSC_CT_PIN_OUT_BIT 2

// reset values
`define OSC_TRIM_RESET 8'h80
`define OSC_SEL_RESET 2'h0

// internal oscillator model: untrimmed period in ref_clk cycles
`define OSC_INT_BASE_CYC 4
// trim step is one part in this many of the untrimmed period
`define OSC_TRIM_UNITS 512
// external rising edges seen before the switch-over
`define OSC_EDGE_WAIT 2'h2

`endif

// ### hdl/osc_pkg.sv
package osc_pkg;
    typedef enum logic [1:0] {
        OSC_SRC_INTERNAL = 2'h0,
        OSC_SRC_EXT_PIN = 2'h1,
        OSC_SRC_RC = 2'h2,
        OSC_SRC_CRYSTAL = 2'h3
    } osc_src_t;

    typedef enum logic [2:0] {
        OSC_SW_INTERNAL = 3'h1,
        OSC_SW_COUNT = 3'h2,
        OSC_SW_ENGAGED = 3'h4
    } osc_sw_state_t;
endpackage : osc_pkg

// ### hdl/osc_edge_tick.sv
`timescale 1ns/1ps
// one-cycle pulse on each rising edge of a sampled source level
module osc_edge_tick (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // source level and tick
    input wire logic level_in,
    output logic tick
);
    logic prev_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level_in;
        end
    end

    assign tick = level_in & ~prev_r;
endmodule : osc_edge_tick

// ### hdl/osc_int_gen.sv
`timescale 1ns/1ps
`include "osc_params.svh"
// internal oscillator model: phase accumulator whose period follows the trim
module osc_int_gen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [7:0] trim,
    // output tick
    output logic tick
);
    localparam int UNITS = `OSC_TRIM_UNITS;
    localparam int BASE = `OSC_INT_BASE_CYC;
    logic [13:0] acc_r;
    logic [13:0] limit;

    // one trim step moves the period by 1/512, close to 0.2 percent
    assign limit = 14'(BASE * (UNITS - 128 + int'(trim)));
    assign tick = run && (acc_r + 14'(UNITS) >= limit);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_r <= 14'h0000;
        end else if (!run) begin
            acc_r <= 14'h0000;
        end else if (tick) begin
            acc_r <= acc_r + 14'(UNITS) - limit;
        end else begin
            acc_r <= acc_r + 14'(UNITS);
        end
    end
endmodule : osc_int_gen

// ### verif/osc_sim_model.sv
`timescale 1ns/1ps
// ============================================================
// system integration side: gates the oscillator, counts clocks
module osc_sim_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // requests from the bench
    input wire logic run_req,
    input wire logic stop_req,
    input wire logic clr,
    // oscillator side
    input wire logic full_rate_clock,
    input wire logic half_rate_clock,
    output logic osc_enable_from_sysctl,
    output logic stop_mode,
    // observed pulse counts
    output logic [15:0] full_cnt,
    output logic [15:0] half_cnt,
    output logic [15:0] bus_cnt
);
    logic bus_ph_r;

    // enable and stop are levels, changed only after an edge
    always_ff @(posedge ref_clk) begin
        osc_enable_from_sysctl <= run_req;
        stop_mode <= stop_req;
    end

    // bus clock is the half rate halved once more
    always_ff @(posedge ref_clk) begin
        if (rst || clr) begin
            full_cnt <= 16'h0;
            half_cnt <= 16'h0;
            bus_cnt <= 16'h0;
            bus_ph_r <= 1'b0;
        end else begin
            full_cnt <= full_cnt + {15'h0, full_rate_clock};
            half_cnt <= half_cnt + {15'h0, half_rate_clock};
            if (half_rate_clock) begin
                bus_ph_r <= ~bus_ph_r;
                bus_cnt <= bus_cnt + {15'h0, bus_ph_r};
            end
        end
    end
endmodule : osc_sim_model

// ### verif/test_osc_clock_source_select.sv
`timescale 1ns/1ps
`include "osc_params.svh"
module test_osc_clock_source_select;
    localparam logic [11:0] A_ST = `OSC_ADDR_STATUS;
    localparam logic [11:0] A_TR = `OSC_ADDR_TRIM;
    localparam logic [11:0] A_CT = `OSC_ADDR_CTRL;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, full_rate_clock, half_rate_clock, pin_o, pin_oe, gpio_sel;
    logic osc_en, stop_m;
    logic [3:1] lvl = 3'h0;
    logic [2:0] mask = 3'h0;
    logic run_req = 1'b1, stop_req = 1'b0, clr = 1'b0;
    logic [15:0] full_cnt, half_cnt, bus_cnt;
    logic [15:0] pin_cnt = 16'h0;
    logic [33:0] notes[$];
    logic [33:0] nt;
    logic [31:0] seed = 32'h00015537;
    int errors = 0;
    int n_compared = 0;
    int m, s;

    osc_clock_source_select i_dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_oscillator_pin(lvl[1]), .resistor_cap_clock(lvl[2]), .crystal_clock(lvl[3]),
        .osc_enable_from_sysctl(osc_en), .stop_mode(stop_m), .monitor_osc_bypass(mask[0]),
        .factory_test_mode_a(mask[1]), .factory_test_mode_b(mask[2]),
        .full_rate_clock(full_rate_clock), .half_rate_clock(half_rate_clock),
        .second_oscillator_pin_o(pin_o), .second_oscillator_pin_oe(pin_oe),
        .port_a_bit4_io_sel(gpio_sel));

    osc_sim_model i_sim (
        .ref_clk(ref_clk), .rst(rst), .run_req(run_req), .stop_req(stop_req), .clr(clr),
        .full_rate_clock(full_rate_clock), .half_rate_clock(half_rate_clock),
        .osc_enable_from_sysctl(osc_en), .stop_mode(stop_m), .full_cnt(full_cnt),
        .half_cnt(half_cnt), .bus_cnt(bus_cnt));

    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (clr) pin_cnt <= 16'h0;
        else if (pin_o && pin_oe) pin_cnt <= pin_cnt + 16'h1;
    end

    // ============================================================
    // checking
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic chk(input logic c);
        cmp({31'h0, c}, 32'h1);
    endtask : chk

    function automatic logic near(input int a, input int b);
        return (a - b <= 1) && (b - a <= 1);
    endfunction : near

    task final_report();
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    // oldest note is matched against each completed transfer
    always @(posedge ref_clk) begin
        if (psel && penable && pready) begin
            nt = notes.pop_front();
            cmp({31'h0, pslverr}, {31'h0, nt[32]});
            if (nt[33]) cmp(prdata, nt[31:0]);
        end
    end

    // ============================================================
    // stimulus
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        notes.push_back({~wr, err, exp});
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            errors++;
            final_report();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask : rd

    // levels held two to four cycles so every edge is sampled
    task automatic ticks(input logic [1:0] src, input int n);
        int i;
        int h;
        for (i = 0; i < n; i++) begin
            h = 2 + int'(rnd() % 32'h3);
            repeat (h) @(posedge ref_clk);
            lvl[src] <= 1'b1;
            repeat (h) @(posedge ref_clk);
            lvl[src] <= 1'b0;
        end
    endtask : ticks

    task automatic window(input int n);
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask : window

    task automatic do_reset();
        rst <= 1'b1;
        lvl <= 3'h0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
    endtask : do_reset

    // 512 cycles at a period of 4*(384+t)/512
    task automatic rate(input logic [7:0] t);
        int e;
        logic [31:0] r;
        e = 65536 / (384 + int'(t));
        r = rnd();
        wr(A_TR, {r[23:0], t});
        rd(A_TR, {24'h0, t});
        window(512);
        chk(int'(full_cnt) >= e - 2 && int'(full_cnt) <= e + 2);
    endtask : rate

    task automatic pin(input logic [2:0] c, input logic oe, input logic gp);
        wr(A_CT, {29'h0, c});
        window(100);
        chk(pin_oe === oe);
        chk(gpio_sel === gp);
        if (oe) chk(near(pin_cnt, full_cnt) && full_cnt > 16'h0);
    endtask : pin

    initial begin
        do_reset();
        rd(A_ST, 32'h0);
        rd(A_TR, 32'h80);
        rd(A_CT, 32'h0);
        apb(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'hFFC, 32'hFFFFFFFF, 32'h0, 1'b1);
        wr(A_ST, 32'h1);
        rd(A_ST, 32'h0);
        window(400);
        chk(near(2 * half_cnt, full_cnt) && full_cnt > 16'h60);
        chk(near(2 * bus_cnt, half_cnt) && bus_cnt > 16'h0);
        rate(8'h00);
        rate(8'hFF);
        rate(8'(rnd()));
        rate(8'h80);
        stop_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        window(40);
        chk(full_cnt === 16'h0 && half_cnt === 16'h0);
        stop_req <= 1'b0;
        run_req <= 1'b0;
        repeat (4) @(posedge ref_clk);
        window(40);
        chk(full_cnt === 16'h0);
        run_req <= 1'b1;
        pin(3'h4, 1'b1, 1'b0);
        pin(3'h6, 1'b1, 1'b0);
        pin(3'h0, 1'b0, 1'b1);
        pin(3'h5, 1'b0, 1'b1);
        pin(3'h7, 1'b0, 1'b0);
        // masked requests, and one with the internal source kept
        for (m = 0; m < 4; m++) begin
            do_reset();
            mask <= (m < 3) ? 3'(1 << m) : 3'h0;
            wr(A_CT, (m < 3) ? 32'h1 : 32'h0);
            ticks(2'h1, 4);
            wr(A_ST, 32'h2);
            ticks(2'h1, 6);
            rd(A_ST, 32'h2);
            mask <= 3'h0;
        end
        for (s = 1; s < 4; s++) begin
            do_reset();
            wr(A_CT, s);
            ticks(2'(s), 8);
            wr(A_ST, 32'h2);
            ticks(2'(s), 2);
            rd(A_ST, 32'h2);
            ticks(2'(s), 1);
            rd(A_ST, 32'h3);
            window(0);
            ticks(2'(s), 10);
            repeat (3) @(posedge ref_clk);
            chk(full_cnt === 16'hA && half_cnt === 16'h5);
            window(40);
            chk(full_cnt === 16'h0);
            rd(A_ST, 32'h3);
        end
        do_reset();
        rd(A_ST, 32'h0);
        rate(8'h80);
        final_report();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        final_report();
    end
endmodule : test_osc_clock_source_select
